// ===== pkg/tsf_pkg.sv
package tsf_pkg;
// Contract
// - A trigger command acts exactly like a group execute trigger.
// - Bus triggers count only when the arm source is bus.
// - Bus arm, infinite count, initiated: one measurement per trigger; the code drops a trigger in a done cycle or while start_q is high.
// - Self-test checksums the ROM and queues 0 for pass, 1 for fail.
// - Queued self-test result goes out only when addressed to talk.
// - Wait-to-continue is accepted and does nothing.
// - Configure selects current function and defaults its controls.
// - Configure sets immediate source, counts one, delay zero.
// - Configure disables math and buffer, enables auto zero.
// - Configure switches both source outputs on.
// - Configure query reports the current function.
// - Fetch returns stored readings without starting or changing anything; the code returns ch1_q only and clears ST_NEW_RD.
// - Repeated fetches return the same readings until new ones arrive.
// - Fetch while armed waits until idle.
// - Unsourced, unmeasured channels read as the not-a-number marker.
// - A measure reading wins over a source reading.
// - Read is initiate then fetch.
// - Measure is configure then read.
// - On return to idle, pending commands execute in order.

    localparam logic [31:0] REG_CMD = 32'h0000_0000;
    localparam logic [31:0] REG_STATUS = 32'h0000_0004;
    localparam logic [31:0] REG_SETUP = 32'h0000_0008;
    localparam logic [31:0] REG_RESULT = 32'h0000_000c;
    localparam logic [31:0] REG_CH1 = 32'h0000_0010;
    localparam logic [31:0] REG_CH2 = 32'h0000_0014;
    localparam logic [31:0] REG_MEAS = 32'h0000_0018;

    // command codes written to REG_CMD
    localparam logic [3:0] CMD_NONE = 4'h0;
    localparam logic [3:0] CMD_TRG = 4'h1;
    localparam logic [3:0] CMD_TST = 4'h2;
    localparam logic [3:0] CMD_WAI = 4'h3;
    localparam logic [3:0] CMD_CONF = 4'h4;
    localparam logic [3:0] CMD_CONFQ = 4'h5;
    localparam logic [3:0] CMD_FETCH = 4'h6;
    localparam logic [3:0] CMD_READ = 4'h7;
    localparam logic [3:0] CMD_MEAS = 4'h8;
    localparam logic [3:0] CMD_INIT = 4'h9;
    localparam logic [3:0] CMD_ABORT = 4'ha;

    // setup register fields
    localparam int SET_ARM_BUS = 0;
    localparam int SET_ARM_INF = 1;
    localparam int SET_TRIG_IMM = 2;
    localparam int SET_MATH = 3;
    localparam int SET_BUF = 4;
    localparam int SET_AZ = 5;
    localparam int SET_OUT1 = 6;
    localparam int SET_OUT2 = 7;
    localparam int SET_FUNC_CURR = 8;
    localparam int SET_CNT_LSB = 16;
    localparam int SET_DLY_LSB = 24;
    localparam logic [31:0] SETUP_RST = 32'h0101_0124;
    localparam logic [31:0] SETUP_CONF = 32'h0001_01e4;

    // status bits
    localparam int ST_ARMED = 0;
    localparam int ST_PEND = 1;
    localparam int ST_RES_VLD = 2;
    localparam int ST_TST_FAIL = 3;
    localparam int ST_NEW_RD = 4;

    localparam logic [31:0] NOT_A_NUMBER_MARKER = 32'h7e95_1a5c;
    localparam logic [31:0] FUNC_CURRENT_CODE = 32'h0000_0001;
    localparam logic [15:0] ROM_SUM_GOOD = 16'h0000;
    localparam int QUEUE_DEPTH = 4;
endpackage

// ===== pkg/tsf_meas_if.sv
`timescale 1ns/1ps
interface tsf_meas_if;
    logic start;
    logic done;
    logic [31:0] src1;
    logic [31:0] src2;
    logic [31:0] mea1;
    logic [31:0] mea2;
    logic [3:0] flags;
    modport ctrl (output start, input done, src1, src2, mea1, mea2, flags);
    modport unit (input start, output done, src1, src2, mea1, mea2, flags);
endinterface

// ===== rtl/tsf_sel.sv
`timescale 1ns/1ps
// per-channel element choice: measure beats source, neither gives marker
module tsf_sel
    import tsf_pkg::*;
(
    input wire logic have_src,
    input wire logic have_meas,
    input wire logic [31:0] src_val,
    input wire logic [31:0] meas_val,
    output logic [31:0] element
);
    always_comb
    begin
        if (have_meas)
            element = meas_val;
        else if (have_src)
            element = src_val;
        else
            element = NOT_A_NUMBER_MARKER;
    end
endmodule

// ===== rtl/tsf_top.sv
`timescale 1ns/1ps
module tsf_top
    import tsf_pkg::*;
#(
    parameter int QDEPTH = QUEUE_DEPTH
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic get_pin,
    input wire logic talk_pin,
    input wire logic [15:0] rom_sum,
    output logic meas_start,
    input wire logic meas_done,
    input wire logic [3:0] meas_flags,
    input wire logic [31:0] src1_val,
    input wire logic [31:0] src2_val,
    input wire logic [31:0] mea1_val,
    input wire logic [31:0] mea2_val,
    output logic [31:0] result_out,
    output logic result_strobe
);
    import tsf_pkg::*;

    if (QDEPTH < 2 || QDEPTH > 16)
        $error("queue depth out of range");

    typedef enum logic [2:0] {TSF_IDLE, TSF_EXEC, TSF_ARMED, TSF_RD_FETCH}
        tsf_state_t;

    localparam int QW = $clog2(QDEPTH);

    tsf_meas_if mif();
    assign meas_start = mif.start;
    assign mif.done = meas_done;
    assign mif.src1 = src1_val;
    assign mif.src2 = src2_val;
    assign mif.mea1 = mea1_val;
    assign mif.mea2 = mea2_val;
    assign mif.flags = meas_flags;

    logic get_s1_q, get_s2_q, get_s3_q;
    logic talk_s1_q, talk_s2_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            get_s1_q <= 1'b0;
            get_s2_q <= 1'b0;
            get_s3_q <= 1'b0;
            talk_s1_q <= 1'b0;
            talk_s2_q <= 1'b0;
        end
        else
        begin
            get_s1_q <= get_pin;
            get_s2_q <= get_s1_q;
            get_s3_q <= get_s2_q;
            talk_s1_q <= talk_pin;
            talk_s2_q <= talk_s1_q;
        end
    end
    wire logic get_evt = get_s2_q & ~get_s3_q;

    wire logic wr = psel & penable & pwrite;
    wire logic rd_acc = psel & penable & ~pwrite;
    wire logic cmd_wr = wr && paddr == REG_CMD;
    wire logic trg_cmd = cmd_wr && pwdata[3:0] == CMD_TRG;
    wire logic abort_cmd = cmd_wr && pwdata[3:0] == CMD_ABORT;
    // triggers and abort bypass the queue so they can act while armed
    wire logic trig_evt = get_evt | trg_cmd;
    wire logic q_push = cmd_wr && !trg_cmd && !abort_cmd &&
        pwdata[3:0] != CMD_NONE;

    logic [3:0] q_mem_q [QDEPTH];
    logic [QW-1:0] q_rd_q, q_wr_q;
    logic [QW:0] q_cnt_q;
    tsf_state_t state_q;
    logic [3:0] cur_q;
    logic [31:0] setup_q;
    logic [31:0] result_q;
    logic res_vld_q, tst_fail_q, new_rd_q;
    logic [31:0] ch1_q, ch2_q;
    logic [31:0] meas_cnt_q;
    logic [7:0] left_q;
    logic read_chain_q;
    logic start_q;
    logic [31:0] ch1_el, ch2_el;

    wire logic q_full = q_cnt_q == QDEPTH[QW:0];
    wire logic q_empty = q_cnt_q == '0;
    wire logic q_pop = state_q == TSF_IDLE && !q_empty;
    wire logic [3:0] q_head = q_mem_q[q_rd_q];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q_rd_q <= '0;
            q_wr_q <= '0;
            q_cnt_q <= '0;
            for (int i = 0; i < QDEPTH; i++)
                q_mem_q[i] <= 4'h0;
        end
        else if (abort_cmd)
        begin
            q_rd_q <= '0;
            q_wr_q <= '0;
            q_cnt_q <= '0;
        end
        else
        begin
            // fifo keeps arrival order
            if (q_push && !q_full)
            begin
                q_mem_q[q_wr_q] <= pwdata[3:0];
                q_wr_q <= QW'((q_wr_q + 1'b1) % QDEPTH);
            end
            if (q_pop)
                q_rd_q <= QW'((q_rd_q + 1'b1) % QDEPTH);
            q_cnt_q <= q_cnt_q + (QW+1)'(q_push && !q_full) -
                (QW+1)'(q_pop);
        end
    end

    tsf_sel u_sel1 (
        .have_src(mif.flags[0]),
        .have_meas(mif.flags[1]),
        .src_val(mif.src1),
        .meas_val(mif.mea1),
        .element(ch1_el)
    );
    tsf_sel u_sel2 (
        .have_src(mif.flags[2]),
        .have_meas(mif.flags[3]),
        .src_val(mif.src2),
        .meas_val(mif.mea2),
        .element(ch2_el)
    );

    wire logic arm_bus = setup_q[SET_ARM_BUS];
    wire logic arm_inf = setup_q[SET_ARM_INF];
    wire logic bus_go = trig_evt && arm_bus && state_q == TSF_ARMED &&
        !start_q;

    // command engine: one command at a time, each finishes before next
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= TSF_IDLE;
            cur_q <= CMD_NONE;
            setup_q <= SETUP_RST;
            result_q <= 32'h0;
            res_vld_q <= 1'b0;
            tst_fail_q <= 1'b0;
            left_q <= 8'h0;
            read_chain_q <= 1'b0;
            start_q <= 1'b0;
        end
        else
        begin
            start_q <= 1'b0;
            if (talk_s2_q && res_vld_q)
                res_vld_q <= 1'b0;
            if (wr && paddr == REG_SETUP && state_q == TSF_IDLE)
                setup_q <= pwdata;
            if (abort_cmd)
            begin
                state_q <= TSF_IDLE;
                read_chain_q <= 1'b0;
            end
            else
            begin
                case (state_q)
                    TSF_IDLE:
                    begin
                        if (q_pop)
                        begin
                            cur_q <= q_head;
                            state_q <= TSF_EXEC;
                        end
                    end
                    TSF_EXEC:
                    begin
                        state_q <= TSF_IDLE;
                        case (cur_q)
                            CMD_TST:
                            begin
                                tst_fail_q <= rom_sum != ROM_SUM_GOOD;
                                result_q <= {31'h0, rom_sum != ROM_SUM_GOOD};
                                res_vld_q <= 1'b1;
                            end
                            CMD_WAI:
                            begin
                                // sequential engine makes this a no-op
                                state_q <= TSF_IDLE;
                            end
                            CMD_CONF, CMD_MEAS:
                            begin
                                setup_q <= SETUP_CONF;
                                if (cur_q == CMD_MEAS)
                                begin
                                    cur_q <= CMD_READ;
                                    state_q <= TSF_EXEC;
                                end
                            end
                            CMD_CONFQ:
                            begin
                                result_q <= FUNC_CURRENT_CODE;
                                res_vld_q <= 1'b1;
                            end
                            CMD_FETCH:
                            begin
                                // stored copy only
                                result_q <= ch1_q;
                                res_vld_q <= 1'b1;
                            end
                            CMD_INIT, CMD_READ:
                            begin
                                read_chain_q <= cur_q == CMD_READ;
                                left_q <= setup_q[SET_CNT_LSB +: 8];
                                state_q <= TSF_ARMED;
                                start_q <= !arm_bus;
                            end
                            default:
                            begin
                                state_q <= TSF_IDLE;
                            end
                        endcase
                    end
                    TSF_ARMED:
                    begin
                        if (bus_go)
                            start_q <= 1'b1;
                        if (mif.done)
                        begin
                            if (!(arm_bus && arm_inf) && left_q <= 8'h1)
                                state_q <= read_chain_q ? TSF_RD_FETCH
                                    : TSF_IDLE;
                            else
                            begin
                                if (!(arm_bus && arm_inf))
                                    left_q <= left_q - 8'h1;
                                start_q <= !arm_bus;
                            end
                        end
                    end
                    TSF_RD_FETCH:
                    begin
                        cur_q <= CMD_FETCH;
                        read_chain_q <= 1'b0;
                        state_q <= TSF_EXEC;
                    end
                    default:
                        state_q <= TSF_IDLE;
                endcase
            end
        end
    end
    assign mif.start = start_q;

    // readings captured only when a measurement finishes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ch1_q <= NOT_A_NUMBER_MARKER;
            ch2_q <= NOT_A_NUMBER_MARKER;
            meas_cnt_q <= 32'h0;
            new_rd_q <= 1'b0;
        end
        else
        begin
            if (state_q == TSF_ARMED && mif.done)
            begin
                ch1_q <= ch1_el;
                ch2_q <= ch2_el;
                meas_cnt_q <= meas_cnt_q + 32'h1;
                new_rd_q <= 1'b1;
            end
            else if (state_q == TSF_EXEC && cur_q == CMD_FETCH)
                new_rd_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            result_out <= 32'h0;
            result_strobe <= 1'b0;
        end
        else
        begin
            result_strobe <= talk_s2_q && res_vld_q;
            if (talk_s2_q && res_vld_q)
                result_out <= result_q;
        end
    end

    assign pready = 1'b1;
    always_comb
    begin
        pslverr = 1'b0;
        prdata = 32'h0;
        if (paddr == REG_STATUS)
            prdata = {27'h0, new_rd_q, tst_fail_q, res_vld_q,
                !q_empty, state_q == TSF_ARMED};
        else if (paddr == REG_SETUP)
            prdata = setup_q;
        else if (paddr == REG_RESULT)
            prdata = result_q;
        else if (paddr == REG_CH1)
            prdata = ch1_q;
        else if (paddr == REG_CH2)
            prdata = ch2_q;
        else if (paddr == REG_MEAS)
            prdata = meas_cnt_q;
        else if (paddr != REG_CMD)
            pslverr = psel & penable;
        if (!rd_acc)
            prdata = 32'h0;
    end

    property p_fetch_held;
        @(posedge pclk) disable iff (!presetn)
        (state_q == TSF_ARMED && !abort_cmd) |=> q_cnt_q >= $past(q_cnt_q);
    endproperty
    a_fetch_held: assert property (p_fetch_held) else $error("fetch ran armed");

    property p_conf_setup;
        @(posedge pclk) disable iff (!presetn)
        (state_q == TSF_EXEC && cur_q == CMD_CONF && !abort_cmd)
        |=> setup_q[SET_OUT1] && setup_q[SET_OUT2] && setup_q[SET_AZ]
            && !setup_q[SET_MATH] && !setup_q[SET_BUF]
            && setup_q[SET_FUNC_CURR];
    endproperty
    a_conf_setup: assert property (p_conf_setup) else $error("conf setup");

    property p_conf_trig;
        @(posedge pclk) disable iff (!presetn)
        (state_q == TSF_EXEC && cur_q == CMD_CONF && !abort_cmd)
        |=> setup_q[SET_TRIG_IMM] && setup_q[SET_CNT_LSB +: 8] == 8'h1
            && setup_q[SET_DLY_LSB +: 8] == 8'h0 && !setup_q[SET_ARM_BUS];
    endproperty
    a_conf_trig: assert property (p_conf_trig) else $error("conf trig");

    property p_no_bus_start;
        @(posedge pclk) disable iff (!presetn)
        (state_q == TSF_ARMED && arm_bus && !$past(bus_go) && !mif.done)
        |-> !start_q || $past(state_q) != TSF_ARMED;
    endproperty
    a_no_bus_start: assert property (p_no_bus_start) else $error("stray start");

    property p_bus_one;
        @(posedge pclk) disable iff (!presetn)
        (bus_go && !abort_cmd) |=> start_q ##1 !start_q;
    endproperty
    a_bus_one: assert property (p_bus_one) else $error("trigger start");

    property p_tst_code;
        @(posedge pclk) disable iff (!presetn)
        (state_q == TSF_EXEC && cur_q == CMD_TST && !abort_cmd)
        |=> result_q == {31'h0, $past(rom_sum) != ROM_SUM_GOOD} && res_vld_q;
    endproperty
    a_tst_code: assert property (p_tst_code) else $error("self-test code");

    property p_talk_only;
        @(posedge pclk) disable iff (!presetn)
        result_strobe |-> $past(talk_s2_q) && $past(res_vld_q);
    endproperty
    a_talk_only: assert property (p_talk_only) else $error("sent untalked");

    property p_fetch_stable;
        @(posedge pclk) disable iff (!presetn)
        !(state_q == TSF_ARMED && mif.done) |=> $stable(ch1_q) && $stable(ch2_q);
    endproperty
    a_fetch_stable: assert property (p_fetch_stable) else $error("reading moved");

    property p_confq;
        @(posedge pclk) disable iff (!presetn)
        (state_q == TSF_EXEC && cur_q == CMD_CONFQ && !abort_cmd)
        |=> result_q == FUNC_CURRENT_CODE;
    endproperty
    a_confq: assert property (p_confq) else $error("conf query");

    c_bus_trig: cover property (@(posedge pclk) disable iff (!presetn) bus_go);
    c_read_done: cover property (@(posedge pclk) disable iff (!presetn)
        state_q == TSF_RD_FETCH);
    c_tst: cover property (@(posedge pclk) disable iff (!presetn)
        state_q == TSF_EXEC && cur_q == CMD_TST);
    c_send: cover property (@(posedge pclk) disable iff (!presetn)
        result_strobe);
endmodule

// ===== testbench/tsf_meas_model.sv
`timescale 1ns/1ps
// stand-in for the source-measure unit: one reading per start, LAT later
module tsf_meas_model #(
    parameter int LAT = 6
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic [3:0] flag_cfg,
    output logic done,
    output logic [3:0] flags,
    output logic [31:0] src1,
    output logic [31:0] src2,
    output logic [31:0] mea1,
    output logic [31:0] mea2
);
    int cnt;
    logic [7:0] n_q;
    logic [7:0] tick_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt <= 0;
            n_q <= 8'h00;
            done <= 1'b0;
            tick_q <= 8'h00;
        end
        else
        begin
            tick_q <= tick_q + 8'h01;
            done <= (cnt == 1);
            if (cnt > 0)
                cnt <= cnt - 1;
            else if (start)
            begin
                cnt <= LAT;
                n_q <= n_q + 8'h01;
            end
        end
    end
    // outside the done pulse the values churn, so a late sample is caught
    assign flags = done ? flag_cfg : ~flag_cfg;
    assign mea1 = done ? {8'h0a, 16'h0000, n_q} : {24'hf5ffff, tick_q};
    assign src1 = done ? {8'h0b, 16'h0000, n_q} : {24'hf4ffff, tick_q};
    assign mea2 = done ? {8'h0c, 16'h0000, n_q} : {24'hf3ffff, tick_q};
    assign src2 = done ? {8'h0d, 16'h0000, n_q} : {24'hf2ffff, tick_q};
endmodule

// ===== testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
    import tsf_pkg::*;
    typedef struct {
        logic [3:0] cmd;
        logic [31:0] setup;
        logic [3:0] flg;
        logic [31:0] exp_setup;
        int exp_meas;
        int exp_out;
    } tsf_row_t;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, last_err;
    logic get_pin, talk_pin, meas_start, meas_done, result_strobe;
    logic [31:0] paddr, pwdata, prdata, result_out, last_res, rd, e1, e2;
    logic [31:0] src1_val, src2_val, mea1_val, mea2_val;
    logic [15:0] rom_sum;
    logic [3:0] meas_flags, flg;
    int fails = 0;
    int n_checks = 0;
    int n_meas = 0;
    int n_str = 0;
    int b_meas, b_str;
    tsf_row_t rows [6];

    tsf_top uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .get_pin(get_pin),
        .talk_pin(talk_pin), .rom_sum(rom_sum), .meas_start(meas_start),
        .meas_done(meas_done), .meas_flags(meas_flags),
        .src1_val(src1_val), .src2_val(src2_val), .mea1_val(mea1_val),
        .mea2_val(mea2_val), .result_out(result_out),
        .result_strobe(result_strobe));
    tsf_meas_model #(.LAT(6)) mdl (
        .pclk(pclk), .presetn(presetn), .start(meas_start),
        .flag_cfg(flg), .done(meas_done), .flags(meas_flags),
        .src1(src1_val), .src2(src2_val), .mea1(mea1_val), .mea2(mea2_val));

    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        if (meas_start === 1'b1)
            n_meas++;
        if (result_strobe === 1'b1)
        begin
            n_str++;
            last_res = result_out;
        end
    end

    task automatic finish_test;
        if (fails == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [31:0] a,
        input logic [31:0] d, output logic [31:0] r);
        int i;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 50; i++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        r = prdata;
        last_err = pslverr;
        if (i == 50)
        begin
            chk(32'h1, 32'h0);
            finish_test();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wait_cnt(ref int c, input int t);
        int i;
        for (i = 0; i < 2000 && c < t; i++)
            @(posedge pclk);
        if (c < t)
        begin
            chk(32'h1, 32'h0);
            finish_test();
        end
    endtask
    task automatic wait_idle;
        int i;
        repeat (4) @(posedge pclk);
        for (i = 0; i < 500; i++)
        begin
            apb(1'b0, REG_STATUS, 32'h0, rd);
            if (rd[ST_ARMED] === 1'b0 && rd[ST_PEND] === 1'b0)
                break;
        end
        if (i == 500)
        begin
            chk(32'h1, 32'h0);
            finish_test();
        end
        repeat (12) @(posedge pclk);
    endtask
    function automatic logic [31:0] elem(logic m, logic s, logic [31:0] mv,
        logic [31:0] sv);
        return m ? mv : (s ? sv : NOT_A_NUMBER_MARKER);
    endfunction

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        get_pin = 1'b0;
        talk_pin = 1'b1;
        rom_sum = 16'h0000;
        flg = 4'h0;
        rows[0] = '{CMD_WAI, 32'h0203_0018, 4'h0, 32'h0203_0018, 0, 0};
        rows[1] = '{CMD_CONF, 32'h0203_0018, 4'h0, SETUP_CONF, 0, 0};
        rows[2] = '{CMD_TRG, 32'h0001_0124, 4'h0, 32'h0001_0124, 0, 0};
        rows[3] = '{CMD_INIT, 32'h0002_0124, 4'h5, 32'h0002_0124, 2, 0};
        rows[4] = '{CMD_MEAS, 32'h0003_0018, 4'h0, SETUP_CONF, 1, 1};
        rows[5] = '{CMD_READ, 32'h0001_0124, 4'hf, 32'h0001_0124, 1, 1};
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, REG_SETUP, 32'h0, rd);
        chk(rd, SETUP_RST);
        apb(1'b0, REG_CH1, 32'h0, rd);
        chk(rd, NOT_A_NUMBER_MARKER);
        apb(1'b0, 32'h0000_0040, 32'h0, rd);
        chk({31'h0, last_err}, 32'h1);
        for (int k = 0; k < 6; k++)
        begin
            flg <= rows[k].flg;
            wait_idle();
            apb(1'b1, REG_SETUP, rows[k].setup, rd);
            b_meas = n_meas;
            b_str = n_str;
            apb(1'b1, REG_CMD, {28'h0, rows[k].cmd}, rd);
            wait_idle();
            apb(1'b0, REG_SETUP, 32'h0, rd);
            chk(rd, rows[k].exp_setup);
            apb(1'b0, REG_MEAS, 32'h0, rd);
            chk(rd, 32'(n_meas));
            chk(32'(n_meas - b_meas), 32'(rows[k].exp_meas));
            e1 = elem(flg[1], flg[0], {8'h0a, 16'h0, 8'(n_meas)},
                {8'h0b, 16'h0, 8'(n_meas)});
            e2 = elem(flg[3], flg[2], {8'h0c, 16'h0, 8'(n_meas)},
                {8'h0d, 16'h0, 8'(n_meas)});
            if (rows[k].exp_meas > 0)
            begin
                apb(1'b0, REG_CH1, 32'h0, rd);
                chk(rd, e1);
                apb(1'b0, REG_CH2, 32'h0, rd);
                chk(rd, e2);
            end
            chk(32'(n_str - b_str), 32'(rows[k].exp_out));
            if (rows[k].exp_out > 0)
                chk(last_res, e1);
        end
        b_meas = n_meas;
        repeat (2)
        begin
            b_str = n_str;
            apb(1'b1, REG_CMD, {28'h0, CMD_FETCH}, rd);
            wait_cnt(n_str, b_str + 1);
            chk(last_res, e1);
        end
        chk(32'(n_meas - b_meas), 32'h0);
        // a slow three-reading run, with a fetch queued behind it
        apb(1'b1, REG_SETUP, 32'h0003_0124, rd);
        b_meas = n_meas;
        b_str = n_str;
        apb(1'b1, REG_CMD, {28'h0, CMD_INIT}, rd);
        repeat (4) @(posedge pclk);
        apb(1'b1, REG_CMD, {28'h0, CMD_FETCH}, rd);
        apb(1'b0, REG_STATUS, 32'h0, rd);
        chk({31'h0, rd[ST_PEND]}, 32'h1);
        chk(32'(n_str - b_str), 32'h0);
        wait_idle();
        chk(32'(n_meas - b_meas), 32'h3);
        chk(32'(n_str - b_str), 32'h1);
        chk(last_res, {8'h0a, 16'h0, 8'(n_meas)});
        apb(1'b1, REG_SETUP, 32'h0001_0127, rd);
        b_meas = n_meas;
        apb(1'b1, REG_CMD, {28'h0, CMD_INIT}, rd);
        repeat (20) @(posedge pclk);
        chk(32'(n_meas - b_meas), 32'h0);
        apb(1'b1, REG_CMD, {28'h0, CMD_TRG}, rd);
        wait_cnt(n_meas, b_meas + 1);
        repeat (20) @(posedge pclk);
        get_pin <= 1'b1;
        repeat (4) @(posedge pclk);
        get_pin <= 1'b0;
        wait_cnt(n_meas, b_meas + 2);
        repeat (40) @(posedge pclk);
        chk(32'(n_meas - b_meas), 32'h2);
        apb(1'b0, REG_STATUS, 32'h0, rd);
        chk({31'h0, rd[ST_NEW_RD]}, 32'h1);
        apb(1'b1, REG_CMD, {28'h0, CMD_ABORT}, rd);
        wait_idle();
        for (int t = 0; t < 2; t++)
        begin
            talk_pin <= 1'b0;
            rom_sum <= 16'(t);
            b_str = n_str;
            apb(1'b1, REG_CMD, {28'h0, CMD_TST}, rd);
            repeat (20) @(posedge pclk);
            chk(32'(n_str - b_str), 32'h0);
            talk_pin <= 1'b1;
            wait_cnt(n_str, b_str + 1);
            chk(last_res, 32'(t));
            apb(1'b0, REG_STATUS, 32'h0, rd);
            chk({31'h0, rd[ST_TST_FAIL]}, 32'(t));
        end
        b_str = n_str;
        apb(1'b1, REG_CMD, {28'h0, CMD_CONFQ}, rd);
        wait_cnt(n_str, b_str + 1);
        chk(last_res, FUNC_CURRENT_CODE);
        // reset in mid-run while bus-armed: status, setup and channel 1 must fall back
        apb(1'b1, REG_SETUP, 32'h0001_0127, rd);
        apb(1'b1, REG_CMD, {28'h0, CMD_INIT}, rd);
        repeat (4) @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, REG_STATUS, 32'h0, rd);
        chk(rd, 32'h0);
        apb(1'b0, REG_SETUP, 32'h0, rd);
        chk(rd, SETUP_RST);
        apb(1'b0, REG_CH1, 32'h0, rd);
        chk(rd, NOT_A_NUMBER_MARKER);
        finish_test();
    end
endmodule
